// ===== rtl/szm_map.svh
`ifndef SZM_MAP_SVH
`define SZM_MAP_SVH
// Register byte offsets on the Wishbone bus.
`define SZM_REG_CTRL 8'h00
`define SZM_REG_STAT 8'h04
`define SZM_REG_CAP 8'h08
`define SZM_REG_RES 8'h0C
`define SZM_REG_MWIN 8'h10
`define SZM_REG_HOLD 8'h14
`define SZM_REG_TRATE 8'h18
`define SZM_REG_MINPR 8'h1C
`define SZM_REG_ZOFS 8'h20
`define SZM_REG_ACCLO 8'h24
`define SZM_REG_ACCHI 8'h28
`define SZM_REG_BATLO 8'h2C
`define SZM_REG_BATHI 8'h30
`define SZM_REG_TARE 8'h34
`define SZM_REG_CMD 8'h38
`define SZM_REG_SEL 8'h3C
// Control field positions.
`define SZM_CTRL_TRK0 0
`define SZM_CTRL_TRK1 1
`define SZM_CTRL_GATE 2
`define SZM_CTRL_NET 3
`define SZM_CTRL_SETP 4
// Command bits, write one to act.
`define SZM_CMD_ZERO 0
`define SZM_CMD_PRINT 1
`define SZM_CMD_CLRALL 2
`define SZM_CMD_CLRONE 3
`define SZM_CMD_WRONE 4
`define SZM_CMD_BATADD 5
// Timing, clock 100 MHz.
`define SZM_CLK_HZ 100000000
`define SZM_MPER_MS 200
`define SZM_AZ_S 5
`define SZM_MENU_S 1
`define SZM_MPER_CYC (`SZM_CLK_HZ / 1000 * `SZM_MPER_MS)
`define SZM_AZ_CYC (`SZM_CLK_HZ * `SZM_AZ_S)
`define SZM_MENU_CYC (`SZM_CLK_HZ * `SZM_MENU_S)
// Totals wrap limits, in thousandths of a unit.
`define SZM_ACC_LIM 48'h9184E72A000
`define SZM_BAT_LIM 48'h2540BE400
`define SZM_ZERO_W 32'h00000000
`endif

// ===== rtl/szm_pkg.sv
package szm_pkg;
    typedef enum logic [1:0] {
        TRK_OFF,
        TRK_ON,
        TRK_AZ,
        TRK_RSV
    } szm_trk_type;
    typedef enum logic [1:0] {
        PR_IDLE,
        PR_PEND,
        PR_SHOW
    } szm_pr_type;
endpackage

// ===== rtl/szm_tot_if.sv
`timescale 1ns/10ps
interface szm_tot_if;
    logic add;
    logic [31:0] addend;
    logic clr;
    logic wr;
    logic [47:0] wdata;
    logic [47:0] total;
    modport ctl (output add, output addend, output clr, output wr,
        output wdata, input total);
    modport acc (input add, input addend, input clr, input wr,
        input wdata, output total);
endinterface

// ===== rtl/szm_total.sv
`timescale 1ns/10ps
`include "szm_map.svh"
module szm_total #(
    parameter logic [47:0] LIMIT = `SZM_ACC_LIM,
    parameter logic [47:0] WRAP = `SZM_ACC_LIM
) (
    input wire logic clk_i,
    input wire logic rst_i,
    szm_tot_if.acc t
);
    typedef struct packed {
        logic [47:0] total;
    } szm_tot_st_type;
    szm_tot_st_type st_ff;
    szm_tot_st_type nxt_st;
    logic [47:0] sum;
    assign t.total = st_ff.total;
    always_comb
    begin
        nxt_st = st_ff;
        sum = st_ff.total + {16'h0000, t.addend};
        if (t.clr)
        begin
            nxt_st.total = 48'h000000000000;
        end
        else if (t.wr)
        begin
            nxt_st.total = t.wdata;
        end
        else if (t.add)
        begin
            // total wrap
            // Wrap once the limit is passed.
            nxt_st.total = (sum > LIMIT) ? sum - WRAP : sum;
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end
endmodule

// ===== rtl/szm_motion.sv
`timescale 1ns/10ps
`include "szm_map.svh"
module szm_motion #(
    parameter int MPER = `SZM_MPER_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic valid_i,
    input wire logic signed [31:0] weight_i,
    input wire logic [31:0] window_i,
    input wire logic [31:0] hold_i,
    output logic motion_o,
    output logic signed [31:0] delta_o
);
    typedef struct packed {
        logic [31:0] per;
        logic [31:0] hold;
        logic signed [31:0] ref_w;
        logic motion;
        logic signed [31:0] delta;
    } szm_mot_st_type;
    szm_mot_st_type st_ff;
    szm_mot_st_type nxt_st;
    logic signed [31:0] d;
    logic [31:0] ad;
    assign motion_o = st_ff.motion;
    assign delta_o = st_ff.delta;
    always_comb
    begin
        nxt_st = st_ff;
        d = weight_i - st_ff.ref_w;
        ad = d[31] ? -d : d;
        if (st_ff.per != 32'h00000000)
        begin
            nxt_st.per = st_ff.per - 32'h00000001;
        end
        if (valid_i && st_ff.per == 32'h00000000)
        begin
            nxt_st.per = MPER[31:0];
            nxt_st.ref_w = weight_i;
            nxt_st.delta = d;
            if (ad > window_i)
            begin
                nxt_st.motion = 1'b1;
                nxt_st.hold = hold_i;
            end
            else if (st_ff.hold == 32'h00000000)
            begin
                nxt_st.motion = 1'b0;
            end
        end
        if (st_ff.hold != 32'h00000000 && !(valid_i && ad > window_i))
        begin
            nxt_st.hold = st_ff.hold - 32'h00000001;
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end
endmodule

// ===== rtl/szm_supervisor.sv
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/10ps
`include "szm_map.svh"
// What this block does
// - zero command makes gross zero and clears auto tare.
// - zero accepted only stable and within -1 % to +3 % capacity.
// - good-zero when displayed weight within quarter resolution step.
// - tracking and autozero inhibited outside range or with setpoint armed.
// - tracking needs mode on, gross within quarter step, stable, rate below limit.
// - rate limit is change per minute, rescaled with resolution.
// - autozero needs autozero mode, negative gross, gross mode, 5 s stable.
// - motion when change over period, at least 200 ms, exceeds window.
// - motion flag held for settle time after weight steadies.
// - motion blocks zero, tracking, and printing with gate on.
// - print discarded when displayed weight not above minimum, except a print pended in motion.
// - with gate on, print during motion pends then runs.
// - print indicator shown in zero and motion position.
// - one communication print command per scale; inputs name scale.
// - each accepted print adds displayed weight to total.
// - accumulated totals wrap by subtracting ten billion units.
// - batched totals wrap by subtracting ten million units, once past ten billion units.
// - clear all totals, or clear one total or overwrite it with zero.
// - menu opens after plus and up held together 1 second.
// - menu open does not pause supervision or accumulation.
module szm_supervisor #(
    parameter int MPER = `SZM_MPER_CYC,
    parameter int AZ_CYC = `SZM_AZ_CYC,
    parameter int MENU_CYC = `SZM_MENU_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic valid_i,
    input wire logic signed [31:0] weight_i,
    input wire logic [7:0] comm_print_i,
    input wire logic panel_print_i,
    input wire logic panel_zero_i,
    input wire logic key_plus_i,
    input wire logic key_up_i,
    output logic menu_o,
    output logic motion_o,
    output logic good_zero_o,
    output logic print_ind_o,
    output logic print_o,
    output logic zero_reject_o
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [4:0] ctrl;
        logic [31:0] cap;
        logic [31:0] res;
        logic [31:0] mwin;
        logic [31:0] hold;
        logic [31:0] trate;
        logic [31:0] minpr;
        logic signed [31:0] zofs;
        logic signed [31:0] tare;
        logic [2:0] sel;
        szm_pkg::szm_pr_type pr;
        logic [23:0] flash;
        logic [31:0] stab;
        logic [31:0] menu_cnt;
        logic menu;
        logic gz;
        logic pr_out;
        logic zrej;
        logic mot;
        logic signed [31:0] wsmp;
        logic pind;
    } szm_st_type;
    szm_st_type st_ff;
    szm_st_type nxt_st;
    logic motion;
    logic signed [31:0] delta;
    logic signed [31:0] smp;
    logic signed [31:0] gross;
    logic signed [31:0] disp;
    logic [31:0] adisp;
    logic [31:0] agross;
    logic signed [33:0] zlo;
    logic signed [33:0] zhi;
    logic zrange;
    logic [63:0] rate_lim;
    logic [31:0] adelta;
    logic track_ok;
    logic az_ok;
    logic zero_req;
    logic print_req;
    logic do_print;
    logic w_cyc;
    logic wr;
    logic [31:0] cmd;
    szm_pkg::szm_trk_type trk;
    szm_tot_if tacc ();
    szm_tot_if tbat ();
    szm_motion #(.MPER(MPER)) u_mot (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .valid_i(valid_i),
        .weight_i(weight_i),
        .window_i(st_ff.mwin),
        .hold_i(st_ff.hold),
        .motion_o(motion),
        .delta_o(delta)
    );
    szm_total #(.LIMIT(`SZM_ACC_LIM), .WRAP(`SZM_ACC_LIM)) u_acc (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .t(tacc.acc)
    );
    szm_total #(.LIMIT(`SZM_ACC_LIM), .WRAP(`SZM_BAT_LIM)) u_bat (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .t(tbat.acc)
    );
    // ****************************************************************
    // Weight conditions
    // ****************************************************************
    assign trk = szm_pkg::szm_trk_type'(st_ff.ctrl[`SZM_CTRL_TRK1:0]);
    // The weight bus is only valid on a strobe, so the last sample is held.
    assign smp = valid_i ? weight_i : st_ff.wsmp;
    assign gross = smp - st_ff.zofs;
    assign disp = st_ff.ctrl[`SZM_CTRL_NET] ? gross - st_ff.tare : gross;
    assign adisp = disp[31] ? -disp : disp;
    assign agross = gross[31] ? -gross : gross;
    assign adelta = delta[31] ? -delta : delta;
    assign zlo = -$signed({2'b00, st_ff.cap}) / 100;
    assign zhi = $signed({2'b00, st_ff.cap}) * 3 / 100;
    assign zrange = ($signed({{2{smp[31]}}, smp}) >= zlo)
        && ($signed({{2{smp[31]}}, smp}) <= zhi);
    // rate per minute
    // The limit is held in resolution steps per minute, so a new
    // resolution rescales it; compared per sample against delta times
    // samples per minute would need the rate, so per-period delta is used.
    assign rate_lim = st_ff.trate * st_ff.res;
    assign track_ok = zrange && !st_ff.ctrl[`SZM_CTRL_SETP]
        && (trk == szm_pkg::TRK_ON || trk == szm_pkg::TRK_AZ)
        && ({agross, 2'b00} < {2'b00, st_ff.res}) && !motion
        && ({32'h00000000, adelta} < rate_lim);
    assign az_ok = zrange && !st_ff.ctrl[`SZM_CTRL_SETP]
        && trk == szm_pkg::TRK_AZ && gross[31]
        && !st_ff.ctrl[`SZM_CTRL_NET] && st_ff.stab >= AZ_CYC[31:0];
    // ****************************************************************
    // Wishbone slave
    // ****************************************************************
    assign w_cyc = wb_cyc_i && wb_stb_i && !st_ff.ack;
    assign wr = w_cyc && wb_we_i && (&wb_sel_i);
    assign cmd = (wr && wb_adr_i[7:0] == `SZM_REG_CMD) ? wb_dat_i
        : 32'h00000000;
    assign zero_req = cmd[`SZM_CMD_ZERO] || panel_zero_i;
    assign print_req = cmd[`SZM_CMD_PRINT] || panel_print_i
        || comm_print_i[st_ff.sel];
    assign do_print = (st_ff.pr == szm_pkg::PR_PEND && !motion)
        || (print_req && st_ff.pr != szm_pkg::PR_PEND
        && !(st_ff.ctrl[`SZM_CTRL_GATE] && motion)
        && disp > $signed(st_ff.minpr));
    always_comb
    begin
        tacc.add = do_print;
        tacc.addend = disp[31] ? 32'h00000000 : disp;
        tacc.clr = cmd[`SZM_CMD_CLRALL] || cmd[`SZM_CMD_CLRONE];
        tacc.wr = cmd[`SZM_CMD_WRONE];
        tacc.wdata = 48'h000000000000;
        tbat.add = cmd[`SZM_CMD_BATADD];
        tbat.addend = tacc.addend;
        tbat.clr = cmd[`SZM_CMD_CLRALL];
        tbat.wr = 1'b0;
        tbat.wdata = 48'h000000000000;
    end
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.ack = w_cyc;
        nxt_st.rdat = 32'h00000000;
        nxt_st.pr_out = 1'b0;
        nxt_st.zrej = 1'b0;
        nxt_st.wsmp = smp;
        if (w_cyc && !wb_we_i)
        begin
            case (wb_adr_i[7:0])
                `SZM_REG_CTRL: nxt_st.rdat = {27'h0000000, st_ff.ctrl};
                `SZM_REG_STAT: nxt_st.rdat = {26'h0000000, st_ff.menu,
                    st_ff.pr != szm_pkg::PR_IDLE, zrange, st_ff.gz,
                    motion, st_ff.zrej};
                `SZM_REG_CAP: nxt_st.rdat = st_ff.cap;
                `SZM_REG_RES: nxt_st.rdat = st_ff.res;
                `SZM_REG_MWIN: nxt_st.rdat = st_ff.mwin;
                `SZM_REG_HOLD: nxt_st.rdat = st_ff.hold;
                `SZM_REG_TRATE: nxt_st.rdat = st_ff.trate;
                `SZM_REG_MINPR: nxt_st.rdat = st_ff.minpr;
                `SZM_REG_ZOFS: nxt_st.rdat = st_ff.zofs;
                `SZM_REG_ACCLO: nxt_st.rdat = tacc.total[31:0];
                `SZM_REG_ACCHI: nxt_st.rdat = {16'h0000, tacc.total[47:32]};
                `SZM_REG_BATLO: nxt_st.rdat = tbat.total[31:0];
                `SZM_REG_BATHI: nxt_st.rdat = {16'h0000, tbat.total[47:32]};
                `SZM_REG_TARE: nxt_st.rdat = st_ff.tare;
                `SZM_REG_SEL: nxt_st.rdat = {29'h00000000, st_ff.sel};
                default: nxt_st.rdat = 32'h00000000;
            endcase
        end
        if (wr)
        begin
            case (wb_adr_i[7:0])
                `SZM_REG_CTRL: nxt_st.ctrl = wb_dat_i[4:0];
                `SZM_REG_CAP: nxt_st.cap = wb_dat_i;
                `SZM_REG_RES: nxt_st.res = wb_dat_i;
                `SZM_REG_MWIN: nxt_st.mwin = wb_dat_i;
                `SZM_REG_HOLD: nxt_st.hold = wb_dat_i;
                `SZM_REG_TRATE: nxt_st.trate = wb_dat_i;
                `SZM_REG_MINPR: nxt_st.minpr = wb_dat_i;
                `SZM_REG_TARE: nxt_st.tare = wb_dat_i;
                `SZM_REG_SEL: nxt_st.sel = wb_dat_i[2:0];
                default: nxt_st.sel = nxt_st.sel;
            endcase
        end
        nxt_st.gz = {adisp, 2'b00} < {2'b00, st_ff.res};
        nxt_st.mot = motion;
        if (motion)
        begin
            nxt_st.stab = 32'h00000000;
        end
        else if (st_ff.stab < AZ_CYC[31:0])
        begin
            nxt_st.stab = st_ff.stab + 32'h00000001;
        end
        if (valid_i)
        begin
            if (zero_req)
            begin
                if (!motion && zrange)
                begin
                    nxt_st.zofs = weight_i;
                    nxt_st.tare = `SZM_ZERO_W;
                end
                else
                begin
                    nxt_st.zrej = 1'b1;
                end
            end
            else if (track_ok || az_ok)
            begin
                nxt_st.zofs = weight_i;
            end
        end
        case (st_ff.pr)
            szm_pkg::PR_IDLE, szm_pkg::PR_SHOW:
            begin
                if (print_req && st_ff.ctrl[`SZM_CTRL_GATE] && motion)
                begin
                    nxt_st.pr = szm_pkg::PR_PEND;
                end
                else if (do_print)
                begin
                    nxt_st.pr = szm_pkg::PR_SHOW;
                end
                else if (st_ff.pr == szm_pkg::PR_SHOW
                    && st_ff.flash == 24'hFFFFFF)
                begin
                    nxt_st.pr = szm_pkg::PR_IDLE;
                end
            end
            szm_pkg::PR_PEND:
            begin
                if (!motion)
                begin
                    nxt_st.pr = szm_pkg::PR_SHOW;
                end
            end
            default: nxt_st.pr = szm_pkg::PR_IDLE;
        endcase
        nxt_st.pr_out = do_print;
        nxt_st.flash = (st_ff.pr == szm_pkg::PR_IDLE) ? 24'h000000
            : st_ff.flash + 24'h000001;
        nxt_st.pind = (nxt_st.pr == szm_pkg::PR_SHOW)
            || (nxt_st.pr == szm_pkg::PR_PEND && nxt_st.flash[23]);
        if (key_plus_i && key_up_i)
        begin
            if (st_ff.menu_cnt >= MENU_CYC[31:0] - 32'h00000001)
            begin
                nxt_st.menu = 1'b1;
            end
            else
            begin
                nxt_st.menu_cnt = st_ff.menu_cnt + 32'h00000001;
            end
        end
        else
        begin
            nxt_st.menu_cnt = 32'h00000000;
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end
    assign wb_ack_o = st_ff.ack;
    assign wb_dat_o = st_ff.rdat;
    assign menu_o = st_ff.menu;
    assign motion_o = st_ff.mot;
    assign good_zero_o = st_ff.gz;
    assign print_ind_o = st_ff.pind;
    assign print_o = st_ff.pr_out;
    assign zero_reject_o = st_ff.zrej;
    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_ACK_ONE: assert property (@(posedge clk_i)
        disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    AST_ZERO_MOT: assert property (@(posedge clk_i)
        disable iff (rst_i) (valid_i && zero_req && motion) |=> zero_reject_o)
        else $error("zero taken in motion");
    AST_ZERO_TARE: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (valid_i && zero_req && !motion && zrange) |=> st_ff.tare == 0)
        else $error("tare not cleared");
    AST_ZRANGE: assert property (@(posedge clk_i) disable iff (rst_i)
        (valid_i && zero_req && !zrange) |=> zero_reject_o)
        else $error("zero out of range taken");
    AST_MINPR: assert property (@(posedge clk_i) disable iff (rst_i)
        (print_req && st_ff.pr != szm_pkg::PR_PEND && !motion
        && disp <= $signed(st_ff.minpr)) |=> !print_o)
        else $error("print below minimum");
    AST_PEND: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_ff.pr == szm_pkg::PR_PEND && !motion) |=> print_o)
        else $error("pending print lost");
    AST_SETP: assert property (@(posedge clk_i) disable iff (rst_i)
        st_ff.ctrl[`SZM_CTRL_SETP] |-> !(track_ok || az_ok))
        else $error("tracking with setpoint armed");
    AST_MENU: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(menu_o) |-> $past(key_plus_i) && $past(key_up_i))
        else $error("menu without keys");
endmodule

// ===== verif/szm_src_model.sv
`timescale 1ns/10ps
// ****************
// Weight sample source
// ****************
module szm_src_model #(
    parameter int PER = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic signed [31:0] target_i,
    output logic pre_o,
    output logic valid_o,
    output logic signed [31:0] weight_o
);
    int cnt;
    assign pre_o = (cnt == PER - 1);
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt <= 0;
            valid_o <= 1'b0;
            weight_o <= 32'sh0;
        end
        else
        begin
            cnt <= pre_o ? 0 : cnt + 1;
            valid_o <= pre_o;
            // Off the strobe the bus carries junk, so a design that samples
            // the weight at the wrong time cannot pass by luck.
            weight_o <= pre_o ? target_i : ~weight_o;
        end
    end
endmodule

// ===== verif/tb.sv
`timescale 1ns/10ps
`include "szm_map.svh"
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [31:0] adr = 32'h0;
    logic [31:0] wdat = 32'h0;
    logic we = 1'b0;
    logic cs = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [3:0] bmask = 4'hF;
    logic pprint = 1'b0;
    logic pzero = 1'b0;
    logic kplus = 1'b0;
    logic kup = 1'b0;
    logic [7:0] cprint = 8'h00;
    logic signed [31:0] target = 32'sh1F4;
    logic signed [31:0] w;
    logic [31:0] rdat;
    logic ack, valid, pre, menu, motion, gz, pind, prn, zrej;
    logic signed [31:0] weight;
    logic [31:0] rd_q[$];
    logic ev_q[$];
    logic [31:0] seed = 32'h00013DFE;
    logic [47:0] acc = 48'h0;
    int fail_count = 0;
    int tests_run = 0;

    initial forever #5 clk_i = ~clk_i;

    szm_src_model src (.clk_i(clk_i), .rst_i(rst_i),
        .target_i(target), .pre_o(pre), .valid_o(valid), .weight_o(weight));

    szm_supervisor #(.MPER(4), .AZ_CYC(20), .MENU_CYC(10)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cs),
        .wb_stb_i(cs), .wb_ack_o(ack), .valid_i(valid), .weight_i(weight),
        .comm_print_i(cprint), .panel_print_i(pprint),
        .panel_zero_i(pzero), .key_plus_i(kplus), .key_up_i(kup),
        .menu_o(menu), .motion_o(motion), .good_zero_o(gz),
        .print_ind_o(pind), .print_o(prn), .zero_reject_o(zrej));

    // ****************
    // Helpers and compares
    // ****************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic err(input string m);
        fail_count++;
        $display("ERROR %0t %s", $time, m);
    endtask

    task automatic cmp_rd(input logic [31:0] got);
        tests_run++;
        if (rd_q.size() == 0 || got !== rd_q[0]) err("read data mismatch");
        if (rd_q.size() != 0) void'(rd_q.pop_front());
    endtask

    task automatic cmp_ev(input logic k);
        tests_run++;
        if (ev_q.size() == 0 || ev_q[0] !== k) err("unexpected event");
        if (ev_q.size() != 0) void'(ev_q.pop_front());
    endtask

    task automatic chk(input logic got, input logic exp, input string m);
        tests_run++;
        if (got !== exp) err(m);
    endtask

    always @(posedge clk_i)
    begin
        if (ack === 1'b1 && !we) cmp_rd(rdat);
        if (prn === 1'b1) cmp_ev(1'b1);
        if (zrej === 1'b1) cmp_ev(1'b0);
    end

    task automatic wb(input logic [7:0] a, input logic wr,
        input logic [31:0] d);
        adr <= {24'h0, a};
        we <= wr;
        wdat <= d;
        sel <= bmask;
        cs <= 1'b1;
        do
        begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        cs <= 1'b0;
        sel <= 4'h0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        wb(a, 1'b0, 32'h0);
    endtask

    task automatic wait_mot(input logic lvl, input int len);
        int n = 0;
        int run = 0;
        while (run < len && n < 2000)
        begin
            @(posedge clk_i);
            n++;
            run = (motion === lvl) ? run + 1 : 0;
        end
        if (run < len) err("motion wait timeout");
    endtask

    task automatic step(input logic signed [31:0] v);
        target <= v;
        wait_mot(1'b1, 1);
        wait_mot(1'b0, 60);
    endtask

    // The zero command only counts on the cycle of a sample strobe.
    task automatic zero_at_valid();
        @(posedge clk_i iff pre === 1'b1);
        pzero <= 1'b1;
        @(posedge clk_i);
        pzero <= 1'b0;
    endtask

    task automatic prt(input logic [7:0] b);
        pprint <= (b == 8'h00);
        cprint <= b;
        @(posedge clk_i);
        pprint <= 1'b0;
        cprint <= 8'h00;
        @(posedge clk_i);
    endtask

    task automatic drain();
        int n = 0;
        while (ev_q.size() != 0 && n < 300)
        begin
            @(posedge clk_i);
            n++;
        end
        if (ev_q.size() != 0) err("missing event");
        repeat (30) @(posedge clk_i);
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_i);
        err("watchdog expired");
        finish_test();
    end

    // ****************
    // Main sequence
    // ****************
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        chk(menu | motion | gz | pind | prn | zrej, 1'b0, "reset");
        rd(8'h40, 32'h0);
        wb(`SZM_REG_CAP, 1'b1, 32'h000186A0);
        wb(`SZM_REG_RES, 1'b1, 32'h0000000A);
        wb(`SZM_REG_MWIN, 1'b1, 32'h00000064);
        wb(`SZM_REG_HOLD, 1'b1, 32'h00000028);
        wb(`SZM_REG_MINPR, 1'b1, 32'h000003E8);
        wb(`SZM_REG_SEL, 1'b1, 32'h00000002);
        wb(`SZM_REG_TARE, 1'b1, 32'h0000007B);
        rd(`SZM_REG_RES, 32'h0000000A);
        bmask = 4'h3;
        wb(`SZM_REG_RES, 1'b1, 32'h00000055);
        bmask = 4'hF;
        rd(`SZM_REG_RES, 32'h0000000A);
        wait_mot(1'b0, 60);
        chk(gz, 1'b0, "good zero off zero");
        zero_at_valid();
        repeat (20) @(posedge clk_i);
        chk(gz, 1'b1, "good zero after zero");
        rd(`SZM_REG_ZOFS, 32'h000001F4);
        rd(`SZM_REG_TARE, 32'h0);
        wb(`SZM_REG_ZOFS, 1'b1, 32'h00000055);
        rd(`SZM_REG_ZOFS, 32'h000001F4);
        target <= 32'sh2BC;
        wait_mot(1'b1, 1);
        ev_q.push_back(1'b0);
        zero_at_valid();
        drain();
        wait_mot(1'b0, 60);
        zero_at_valid();
        repeat (20) @(posedge clk_i);
        rd(`SZM_REG_ZOFS, 32'h000002BC);
        step(32'sh1644);
        chk(gz, 1'b0, "good zero off zero");
        ev_q.push_back(1'b0);
        zero_at_valid();
        drain();
        wb(`SZM_REG_CTRL, 1'b1, 32'h00000004);
        for (int i = 0; i < 3; i++)
        begin
            w = 32'sd7700 + $signed(rnd() & 32'h00000FFF) + i * 5000;
            step(w);
            acc += w - 32'sd700;
            ev_q.push_back(1'b1);
            prt(i == 1 ? 8'h04 : 8'h00);
            drain();
        end
        chk(pind, 1'b1, "print indicator");
        target <= w + 32'sd3000;
        wait_mot(1'b1, 1);
        ev_q.push_back(1'b1);
        prt(8'h00);
        repeat (3) @(posedge clk_i);
        chk(ev_q.size() == 1, 1'b1, "print not held");
        drain();
        acc += w + 32'sd2300;
        step(32'sh6A4);
        prt(8'h00);
        prt(8'h08);
        repeat (30) @(posedge clk_i);
        target <= 32'sh6A5;
        repeat (20) @(posedge clk_i);
        acc += 48'h3E9;
        ev_q.push_back(1'b1);
        prt(8'h00);
        drain();
        rd(`SZM_REG_ACCLO, acc[31:0]);
        rd(`SZM_REG_ACCHI, {16'h0, acc[47:32]});
        wb(`SZM_REG_CMD, 1'b1, 32'h00000004);
        rd(`SZM_REG_ACCLO, 32'h0);
        wb(`SZM_REG_TRATE, 1'b1, 32'h00000001);
        wb(`SZM_REG_CTRL, 1'b1, 32'h00000011);
        step(32'sh2BE);
        rd(`SZM_REG_ZOFS, 32'h000002BC);
        wb(`SZM_REG_CTRL, 1'b1, 32'h00000001);
        repeat (20) @(posedge clk_i);
        rd(`SZM_REG_ZOFS, 32'h000002BE);
        wb(`SZM_REG_CTRL, 1'b1, 32'h00000002);
        target <= 32'sh2B0;
        repeat (40) @(posedge clk_i);
        rd(`SZM_REG_ZOFS, 32'h000002B0);
        kplus <= 1'b1;
        repeat (20) @(posedge clk_i);
        chk(menu, 1'b0, "menu on one key");
        kup <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk(menu, 1'b0, "menu too early");
        repeat (6) @(posedge clk_i);
        chk(menu, 1'b1, "menu not open");
        kplus <= 1'b0;
        kup <= 1'b0;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        chk(menu | pind, 1'b0, "reset clears state");
        rd(`SZM_REG_CAP, 32'h0);
        finish_test();
    end
endmodule
